// ==== bench/mdh_checker.sv ====
// checker for the management host: frame timing and line ownership
`timescale 1ns/1ps
module mdh_checker #(
    parameter int CLK_HZ      = 20_000_000,
    parameter int HALF_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire logic op_read,
    input wire logic busy,
    input wire logic done,
    input wire logic clock_in_range,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe_b
);
    localparam int HC = HALF_CYCLES;
    localparam int FA = 1 + 128 * HALF_CYCLES;
    localparam int FB = 2 + 128 * HALF_CYCLES;
    localparam int DP = 34 * HALF_CYCLES;
    localparam bit IN_R = CLK_HZ >= 12_500_000 && CLK_HZ <= 120_000_000;
    logic rd_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // remember the kind of frame in flight
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) rd_q <= 1'b0;
        else if (start && !busy) rd_q <= op_read;
    end
    AST_TAKE: assert property (start && !busy |=> busy && !mdio_oe_b)
        else $error("frame did not start");
    AST_LEN: assert property (start && !busy |-> ##[FA:FB] done)
        else $error("frame length wrong");
    AST_IDLE: assert property (!busy |-> !mdc && mdio_oe_b)
        else $error("line active while idle");
    AST_EDGE: assert property (busy && $past(busy)
        && ($changed(mdio_out) || $changed(mdio_oe_b)) |-> $fell(mdc))
        else $error("data moved off mdc fall");
    AST_HIGH: assert property ($rose(mdc) |-> ##HC $fell(mdc))
        else $error("mdc high phase wrong");
    AST_LOW: assert property ($fell(mdc) && busy |-> ##HC $rose(mdc))
        else $error("mdc low phase wrong");
    AST_OWN: assert property (done |-> $past(mdio_oe_b, DP) == rd_q)
        else $error("line owner wrong late in frame");
    AST_WRDRV: assert property (busy && !rd_q |-> !mdio_oe_b)
        else $error("write frame released line");
    AST_RANGE: assert property ($past(rst_b) |-> clock_in_range == IN_R)
        else $error("clock range flag wrong");
    COV_WR: cover property (start && !busy && !op_read);
    COV_RD: cover property (start && !busy && op_read);
    COV_REFUSE: cover property (start && busy);
endmodule : mdh_checker

bind mdh_host mdh_checker #(.CLK_HZ(CLK_HZ), .HALF_CYCLES(HALF_CYCLES)) mdh_checker_inst (
    .clock(clock), .rst_b(rst_b), .start(start), .op_read(op_read), .busy(busy),
    .done(done), .clock_in_range(clock_in_range), .mdc(mdc), .mdio_out(mdio_out),
    .mdio_oe_b(mdio_oe_b));

// ==== bench/mdh_phy_model.sv ====
// behavioural transceiver answering management frames at one address
`timescale 1ns/1ps
module mdh_phy_model #(
    parameter logic [4:0] ADDR = 5'h03 // avoids the special 0 and 31
) (
    input  wire logic mdc,
    input  wire logic mdio,
    output logic      drive,
    output logic      bit_out
);
    logic [15:0] regs [32]; // standard and vendor halves alike
    logic [63:0] sh = '0;
    logic [4:0]  rg = '0;
    logic        rd = 1'b0;
    int          n = 0;
    initial foreach (regs[i]) regs[i] = 16'h0000;
    // sample on mdc rise; sync on 32 ones then the start zero
    always @(posedge mdc) begin
        if (n == 0 && &sh[31:0] && !mdio) n = 33;
        else if (n > 0) n = n + 1;
        sh = {sh[62:0], mdio};
        if (n == 46) begin
            rd = sh[11:10] == 2'b10 && sh[9:5] == ADDR;
            rg = sh[4:0];
        end
        if (n == 64) begin
            if (sh[29:28] == 2'b01 && sh[27:23] == ADDR) regs[sh[22:18]] = sh[15:0];
            n = 0;
        end
    end
    // drive only turnaround zero and read data, changed on mdc fall
    always @(negedge mdc) begin
        drive = rd && n >= 47;
        bit_out = (n >= 48) ? regs[rg][63 - n] : 1'b0;
    end
endmodule : mdh_phy_model

// ==== bench/tb.sv ====
// self-checking bench for the management host
`timescale 1ns/1ps
module tb;
    import mdh_pkg::*;
    logic        clock = 0, rst_b = 0, start = 0, op_read = 0;
    mdh_addr_t   phy_addr = '0, reg_addr = '0;
    mdh_data_t   wr_data = '0, rd_data;
    logic        busy, done, clock_in_range, mdc, mdio_out, mdio_oe_b, drive, bit_out;
    logic [63:0] fr = '0;
    int          n_errors = 0, checks = 0;
    // host when enabled, else the transceiver, else the pull-up
    // the model's drive is unknown until its first mdc fall, so only a firm 1 overrides the pull-up
    wire mdio_line = !mdio_oe_b ? mdio_out : ((drive === 1'b1) ? bit_out : 1'b1);
    always #25 clock = ~clock;
    // bits as the transceiver sees them
    always @(posedge mdc) fr <= {fr[62:0], mdio_line};
    mdh_host mdh_host_inst (.clock(clock), .rst_b(rst_b), .start(start), .op_read(op_read),
        .phy_addr(phy_addr), .reg_addr(reg_addr), .wr_data(wr_data), .busy(busy),
        .done(done), .rd_data(rd_data), .clock_in_range(clock_in_range), .mdc(mdc),
        .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b));
    mdh_phy_model mdh_phy_model_inst (.mdc(mdc), .mdio(mdio_line), .drive(drive),
        .bit_out(bit_out));
    task chk(input logic c);
        checks++;
        if (c !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t flag", $time);
        end
    endtask : chk
    task cmp(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // one frame; wd is the expected data for reads; poke retries start mid-frame
    task xfer(input logic rd, input mdh_addr_t pa, rg, input mdh_data_t wd, input logic poke);
        int          k;
        logic [63:0] ef;
        @(negedge clock);
        {start, op_read, phy_addr, reg_addr, wr_data} = {1'b1, rd, pa, rg, wd};
        k = 0;
        do begin
            @(negedge clock);
            k++;
            start = poke && k == 100;
        end while (done !== 1'b1 && k < 700);
        // line image; a read of an absent transceiver sees only the pull-up
        ef = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, pa, rg,
              (rd && pa != 5'h03) ? 2'b11 : 2'b10, wd};
        chk(k == 513 || k == 514);
        cmp(fr, ef);
        if (rd) cmp({48'h0, rd_data}, {48'h0, wd});
        if (poke) begin
            repeat (3) @(negedge clock);
            chk(busy === 1'b0);
        end
    endtask : xfer
    task t_reset;
        @(negedge clock);
        chk(clock_in_range === 1'b1);
        chk(mdc === 1'b0 && mdio_oe_b === 1'b1 && busy === 1'b0);
    endtask : t_reset
    task t_write_read;
        xfer(1'b0, 5'h03, 5'h10, 16'ha5c3, 1'b0);
        xfer(1'b1, 5'h03, 5'h10, 16'ha5c3, 1'b0);
        xfer(1'b0, 5'h03, 5'h01, 16'h3c5a, 1'b1);
        xfer(1'b1, 5'h03, 5'h01, 16'h3c5a, 1'b0);
    endtask : t_write_read
    task t_addr;
        xfer(1'b0, 5'h05, 5'h10, 16'h0f0f, 1'b0);
        xfer(1'b1, 5'h03, 5'h10, 16'ha5c3, 1'b0);
        xfer(1'b1, 5'h05, 5'h10, 16'hffff, 1'b0);
    endtask : t_addr
    task print_verdict;
        if (n_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // main sequence after twelve cycles of reset
    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock) rst_b = 1'b1;
        t_reset;
        t_write_read;
        t_addr;
        print_verdict;
    end
    // watchdog: about twice the expected run
    initial begin
        #400000;
        n_errors++;
        print_verdict;
    end
endmodule : tb

// ==== rtl/mdh_host.sv ====
// serial management host: frames reads and writes to transceivers over mdc and mdio
`timescale 1ns/1ps
module mdh_host #(
    parameter int CLK_HZ      = mdh_pkg::CLK_HZ,
    parameter int HALF_CYCLES = mdh_pkg::MDC_HALF_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                rst_b,
    // user side
    input  wire logic                start,
    input  wire logic                op_read,
    input  wire mdh_pkg::mdh_addr_t  phy_addr,
    input  wire mdh_pkg::mdh_addr_t  reg_addr,
    input  wire mdh_pkg::mdh_data_t  wr_data,
    output logic                     busy,
    output logic                     done,
    output mdh_pkg::mdh_data_t       rd_data,
    output logic                     clock_in_range,
    // management pins
    output logic                     mdc,
    input  wire logic                mdio_in,
    output logic                     mdio_out,
    output logic                     mdio_oe_b
);
    import mdh_pkg::*;

    typedef struct packed {
        mdh_state_t st;
        logic [5:0] cnt;
        logic [63:0] sh;
        logic       rd_op;
        mdh_data_t  rd_sh;
        mdh_data_t  rd_data;
        logic       sync1;
        logic       sync2;
        logic       mdc;
        logic       mdo;
        logic       oe_b;
        logic       busy;
        logic       done;
        logic       in_range;
    } mdh_host_t;

    mdh_host_t s;
    mdh_host_t next_s;
    logic      rise_en;
    logic      fall_en;

    // assemble one whole frame, first line bit in the msb
    function automatic logic [63:0] build_frame(input logic rd, input mdh_addr_t pa,
                                                input mdh_addr_t rg, input mdh_data_t wd);
        logic [63:0] f;
        f = {{PREAMBLE_BITS{1'b1}},
             START_CODE,
             (rd ? OP_READ : OP_WRITE),
             pa,
             rg,
             (rd ? 2'b11 : TA_WRITE),
             (rd ? 16'hffff : wd)};
        return f;
    endfunction : build_frame

    // the host drives a bit unless it lies in a read's turnaround or data field
    function automatic logic released(input logic rd, input logic [5:0] idx);
        return rd && (idx >= TA_BIT);
    endfunction : released

    // the one mdc source; transceivers only listen to it
    mdh_mdc_div #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_div (
        .clock   (clock),
        .rst_b   (rst_b),
        .run     (s.st == MDH_SHIFT),
        .rise_en (rise_en),
        .fall_en (fall_en)
    );

    // next state of the whole host
    always_comb begin
        next_s          = s;
        next_s.done     = 1'b0;
        next_s.sync1    = mdio_in;
        next_s.sync2    = s.sync1;
        next_s.in_range = (CLK_HZ >= CLK_MIN_HZ) && (CLK_HZ <= CLK_MAX_HZ);
        unique case (s.st)
            MDH_IDLE: begin
                // frames only ever begin here, on a user request
                if (start) begin
                    next_s.st    = MDH_SHIFT;
                    next_s.cnt   = 6'h00;
                    next_s.rd_op = op_read;
                    next_s.sh    = build_frame(op_read, phy_addr, reg_addr, wr_data);
                    next_s.mdo   = 1'b1;
                    next_s.oe_b  = 1'b0;
                    next_s.busy  = 1'b1;
                    next_s.mdc   = 1'b0;
                end
            end
            MDH_SHIFT: begin
                if (rise_en) begin
                    next_s.mdc = 1'b1;
                    // read data sampled at the rising edge, through the synchroniser
                    if (s.rd_op && s.cnt >= DATA_BIT) begin
                        next_s.rd_sh = {s.rd_sh[14:0], s.sync2};
                    end
                end else if (fall_en) begin
                    next_s.mdc = 1'b0;
                    if (s.cnt == LAST_BIT) begin
                        // end of frame: hand back data, let the pull-up idle the line
                        next_s.st      = MDH_IDLE;
                        next_s.busy    = 1'b0;
                        next_s.done    = 1'b1;
                        next_s.oe_b    = 1'b1;
                        next_s.mdo     = 1'b1;
                        if (s.rd_op) begin
                            next_s.rd_data = s.rd_sh;
                        end
                    end else begin
                        // new bit goes out half a period before its rising edge
                        next_s.cnt  = s.cnt + 6'h01;
                        next_s.sh   = {s.sh[62:0], 1'b1};
                        next_s.mdo  = s.sh[62];
                        next_s.oe_b = released(s.rd_op, s.cnt + 6'h01);
                    end
                end
            end
        endcase
    end

    // single register stage for all state; line released and mdc low at reset
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s          <= '0;
            s.st       <= MDH_IDLE;
            s.oe_b     <= 1'b1;
            s.mdo      <= 1'b1;
            s.sync1    <= 1'b1;
            s.sync2    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign busy           = s.busy;
    assign done           = s.done;
    assign rd_data        = s.rd_data;
    assign clock_in_range = s.in_range;
    assign mdc            = s.mdc;
    assign mdio_out       = s.mdo;
    assign mdio_oe_b      = s.oe_b;

endmodule : mdh_host

// ==== rtl/mdh_mdc_div.sv ====
// divider that paces mdc: alternating rise and fall enable pulses while running
`timescale 1ns/1ps
module mdh_mdc_div #(
    parameter int HALF_CYCLES = mdh_pkg::MDC_HALF_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic run,
    output logic      rise_en,
    output logic      fall_en
);
    import mdh_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
        logic       high;
        logic       rise;
        logic       fall;
    } mdh_div_t;

    mdh_div_t s;
    mdh_div_t next_s;

    // first pulse after run is always a rise, so bit 0 gets a full half period of setup
    always_comb begin
        next_s      = s;
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (!run) begin
            next_s.cnt  = 8'h00;
            next_s.high = 1'b0;
        end else if (s.cnt == 8'(HALF_CYCLES - 1)) begin
            next_s.cnt  = 8'h00;
            next_s.high = ~s.high;
            next_s.rise = ~s.high;
            next_s.fall = s.high;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise_en = s.rise;
    assign fall_en = s.fall;

endmodule : mdh_mdc_div

// ==== rtl/mdh_pkg.sv ====
// constants and types for the serial management host toward external transceivers
package mdh_pkg;

    typedef logic [4:0]  mdh_addr_t;
    typedef logic [15:0] mdh_data_t;

    // frame layout, bit 0 is the first bit on the line
    localparam int        PREAMBLE_BITS = 32;
    localparam int        FRAME_BITS    = 64;
    localparam int        TA_INDEX      = 46;
    localparam int        DATA_INDEX    = 48;
    localparam logic [1:0] START_CODE   = 2'b01;
    localparam logic [1:0] OP_READ      = 2'b10;
    localparam logic [1:0] OP_WRITE     = 2'b01;
    localparam logic [1:0] TA_WRITE     = 2'b10;
    localparam logic [5:0] LAST_BIT     = 6'h3f;
    localparam logic [5:0] TA_BIT       = 6'h2e;
    localparam logic [5:0] DATA_BIT     = 6'h30;

    // clocking: core clock rate and the permitted range for it
    localparam int CLK_HZ       = 20_000_000;
    localparam int CLK_MIN_HZ   = 12_500_000;
    localparam int CLK_MAX_HZ   = 120_000_000;
    localparam int CLK_PERIOD_NS = 50;
    // shortest mdc period; half of it rounds up to whole core cycles
    localparam int MDC_PERIOD_NS = 400;
    localparam int MDC_HALF_CALC = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MDC_HALF_CYCLES = (MDC_HALF_CALC < 1) ? 1 : MDC_HALF_CALC;

    typedef enum logic {MDH_IDLE, MDH_SHIFT} mdh_state_t;

endpackage : mdh_pkg
